// ---- logic/ossel_top.sv ----
module ossel_top #(
    parameter int FAILSAFE_CYCLES = ossel_pkg::FAILSAFE_TIMEOUT,
    parameter int STARTUP_COUNT   = ossel_pkg::STARTUP_OSC_COUNT,
    parameter int FAST_CYCLES     = ossel_pkg::FAST_START_CYCLES
) (
    // Clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // Configuration
    input  wire logic [2:0] osc_type_cfg,
    input  wire logic       cfg_mult_enable,
    input  wire logic       failsafe_enable,
    input  wire logic       two_speed_enable,
    // Software control
    input  wire logic [1:0] sysclk_source_sel,
    input  wire logic [3:0] int_freq_sel,
    input  wire logic       soft_mult_enable,
    input  wire logic       soft_mult_select,
    // Events
    input  wire logic       powerup_timer_done,
    input  wire logic       wake_event,
    // Pins
    input  wire logic       osc_input_pin,
    // Status and steering
    output      logic [2:0] clk_source_ff,
    output      logic [1:0] amp_gain_ff,
    output      logic [1:0] mult_mode_ff,
    output      logic [3:0] int_freq_ff,
    output      logic       cpu_run_ff,
    output      logic       startup_busy_ff,
    output      logic       failsafe_trip_ff,
    output      logic       osc_stable_ff
);

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    function automatic logic is_crystal(input logic [2:0] t);
        is_crystal = (t == ossel_pkg::OSC_TYPE_WATCH_XTAL) ||
                     (t == ossel_pkg::OSC_TYPE_MID_XTAL) ||
                     (t == ossel_pkg::OSC_TYPE_HIGH_XTAL);
    endfunction : is_crystal

    function automatic logic is_external(input logic [2:0] t);
        is_external = (t != ossel_pkg::OSC_TYPE_INTERNAL);
    endfunction : is_external

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [2:0] osc_sync_ff;
    logic       pup_meta_ff;
    logic       pup_sync_ff;
    logic       wake_meta_ff;
    logic       wake_sync_ff;
    logic       pup_prev_ff;
    logic       wake_prev_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            osc_sync_ff  <= '0;
            pup_meta_ff  <= 1'b0;
            pup_sync_ff  <= 1'b0;
            wake_meta_ff <= 1'b0;
            wake_sync_ff <= 1'b0;
            pup_prev_ff  <= 1'b0;
            wake_prev_ff <= 1'b0;
        end else if (clk_en) begin
            osc_sync_ff  <= {osc_sync_ff[1:0], osc_input_pin};
            pup_meta_ff  <= powerup_timer_done;
            pup_sync_ff  <= pup_meta_ff;
            wake_meta_ff <= wake_event;
            wake_sync_ff <= wake_meta_ff;
            pup_prev_ff  <= pup_sync_ff;
            wake_prev_ff <= wake_sync_ff;
        end
    end

    logic osc_rise;
    logic trigger;
    logic crystal;

    assign osc_rise = osc_sync_ff[1] && !osc_sync_ff[2];
    assign crystal  = is_crystal(osc_type_cfg);
    assign trigger  = (pup_sync_ff && !pup_prev_ff) ||
                      (wake_sync_ff && !wake_prev_ff);

    // ****************************************************************
    // Crystal start-up timer
    // ****************************************************************
    localparam int STW = $clog2(STARTUP_COUNT) + 1;
    localparam logic [STW-1:0] STARTUP_TARGET = STW'(STARTUP_COUNT);

    logic xtal_done;

    ossel_timer #(
        .WIDTH   (STW)
    ) u_crystal_startup_timer (
        .mclk    (mclk),
        .reset   (reset),
        .clk_en  (clk_en),
        .restart (trigger),
        .tick    (osc_rise && crystal && startup_busy_ff),
        .target  (STARTUP_TARGET),
        .done_ff (xtal_done)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            startup_busy_ff <= 1'b0;
        end else if (clk_en) begin
            if (trigger && crystal) begin
                startup_busy_ff <= 1'b1;
            end else if (xtal_done || !crystal) begin
                startup_busy_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Fast start-up settle counter
    // ****************************************************************
    localparam int FW = $clog2(FAST_CYCLES + 1);
    logic [FW-1:0] fast_cnt_ff;
    logic          fast_ready;

    assign fast_ready = (fast_cnt_ff == FW'(FAST_CYCLES));

    always_ff @(posedge mclk) begin
        if (reset) begin
            fast_cnt_ff <= '0;
        end else if (clk_en && !fast_ready) begin
            fast_cnt_ff <= fast_cnt_ff + 1'b1;
        end
    end

    // ****************************************************************
    // Fail-safe clock monitor
    // ****************************************************************
    localparam int MW = $clog2(FAILSAFE_CYCLES + 1);
    logic [MW-1:0] mon_cnt_ff;
    logic          mon_active;

    assign mon_active = failsafe_enable && (osc_type_cfg != ossel_pkg::OSC_TYPE_INTERNAL) &&
                        !startup_busy_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            mon_cnt_ff <= '0;
        end else if (clk_en) begin
            if (osc_rise || !mon_active) begin
                mon_cnt_ff <= '0;
            end else if (mon_cnt_ff != MW'(FAILSAFE_CYCLES)) begin
                mon_cnt_ff <= mon_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            failsafe_trip_ff <= 1'b0;
        end else if (clk_en) begin
            if (mon_active && (mon_cnt_ff == MW'(FAILSAFE_CYCLES))) begin
                failsafe_trip_ff <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // System clock source selection
    // ****************************************************************
    ossel_pkg::ossel_src_t nxt_src;
    logic                  int_block;

    always_comb begin
        int_block = sysclk_source_sel[1] || !is_external(osc_type_cfg) ||
                    failsafe_trip_ff;
        if (int_block) begin
            if (!fast_ready) begin
                nxt_src = ossel_pkg::SRC_FAST_START;
            end else if (int_freq_sel == 4'h0) begin
                nxt_src = ossel_pkg::SRC_SLOW_INT;
            end else begin
                nxt_src = ossel_pkg::SRC_FAST_INT;
            end
        end else if (sysclk_source_sel == ossel_pkg::SRC_SEL_SECONDARY) begin
            nxt_src = ossel_pkg::SRC_SECONDARY;
        end else if (startup_busy_ff && (failsafe_enable || two_speed_enable)) begin
            nxt_src = fast_ready ? ossel_pkg::SRC_FAST_INT
                                 : ossel_pkg::SRC_FAST_START;
        end else begin
            nxt_src = ossel_pkg::SRC_EXTERNAL;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            clk_source_ff <= 3'(ossel_pkg::SRC_FAST_START);
        end else if (clk_en) begin
            clk_source_ff <= 3'(nxt_src);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            int_freq_ff <= ossel_pkg::IRCF_RESET;
        end else if (clk_en) begin
            int_freq_ff <= int_freq_sel;
        end
    end

    // ****************************************************************
    // Execution gate
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_run_ff <= 1'b0;
        end else if (clk_en) begin
            cpu_run_ff <= !(startup_busy_ff && !failsafe_enable && !two_speed_enable &&
                           (nxt_src == ossel_pkg::SRC_EXTERNAL));
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            osc_stable_ff <= 1'b0;
        end else if (clk_en) begin
            osc_stable_ff <= crystal ? xtal_done : 1'b1;
        end
    end

    // ****************************************************************
    // Amplifier gain
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            amp_gain_ff <= ossel_pkg::GAIN_OFF;
        end else if (clk_en) begin
            case (osc_type_cfg)
                ossel_pkg::OSC_TYPE_WATCH_XTAL: amp_gain_ff <= ossel_pkg::GAIN_LOW;
                ossel_pkg::OSC_TYPE_MID_XTAL:   amp_gain_ff <= ossel_pkg::GAIN_MID;
                ossel_pkg::OSC_TYPE_HIGH_XTAL:  amp_gain_ff <= ossel_pkg::GAIN_HIGH;
                ossel_pkg::OSC_TYPE_EXT_HIGH,
                ossel_pkg::OSC_TYPE_EXT_MID,
                ossel_pkg::OSC_TYPE_EXT_LOW:    amp_gain_ff <= ossel_pkg::GAIN_OFF;
                default:                        amp_gain_ff <= ossel_pkg::GAIN_OFF;
            endcase
        end
    end

    // ****************************************************************
    // Frequency multiplier
    // ****************************************************************
    logic mult_on;

    assign mult_on = cfg_mult_enable || soft_mult_enable;

    always_ff @(posedge mclk) begin
        if (reset) begin
            mult_mode_ff <= ossel_pkg::MULT_BYPASS;
        end else if (clk_en) begin
            if (!mult_on) begin
                mult_mode_ff <= ossel_pkg::MULT_BYPASS;
            end else if (soft_mult_select) begin
                mult_mode_ff <= ossel_pkg::MULT_X3;
            end else begin
                mult_mode_ff <= ossel_pkg::MULT_X4;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_gain_high;
        @(posedge mclk) disable iff (reset)
        (clk_en && osc_type_cfg == ossel_pkg::OSC_TYPE_HIGH_XTAL) |=>
            amp_gain_ff == ossel_pkg::GAIN_HIGH;
    endproperty
    a_gain_high: assert property (p_gain_high) else $error("gain not high");

    property p_mult_x3;
        @(posedge mclk) disable iff (reset)
        (clk_en && cfg_mult_enable && soft_mult_select) |=> mult_mode_ff == ossel_pkg::MULT_X3;
    endproperty
    a_mult_x3: assert property (p_mult_x3) else $error("cfg enable not honoured");

    property p_mult_x4;
        @(posedge mclk) disable iff (reset)
        (clk_en && soft_mult_enable && !soft_mult_select) |=> mult_mode_ff == ossel_pkg::MULT_X4;
    endproperty
    a_mult_x4: assert property (p_mult_x4) else $error("4x not chosen");

    property p_freeze;
        @(posedge mclk) disable iff (reset)
        !clk_en |=> $stable(clk_source_ff) && $stable(amp_gain_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    property p_int_sel;
        @(posedge mclk) disable iff (reset)
        (clk_en && sysclk_source_sel[1]) |=>
            clk_source_ff != 3'(ossel_pkg::SRC_EXTERNAL);
    endproperty
    a_int_sel: assert property (p_int_sel) else $error("internal not selected");

    property p_trip_int;
        @(posedge mclk) disable iff (reset)
        (failsafe_trip_ff && clk_en) |=> clk_source_ff != 3'(ossel_pkg::SRC_EXTERNAL);
    endproperty
    a_trip_int: assert property (p_trip_int) else $error("no fallback");

    sequence s_stalled;
        startup_busy_ff && !failsafe_enable && !two_speed_enable &&
        !sysclk_source_sel[1] && sysclk_source_sel != ossel_pkg::SRC_SEL_SECONDARY &&
        is_external(osc_type_cfg) && !failsafe_trip_ff && clk_en;
    endsequence

    property p_stall;
        @(posedge mclk) disable iff (reset)
        s_stalled |=> !cpu_run_ff;
    endproperty
    a_stall: assert property (p_stall) else $error("cpu ran during start-up");

    property p_ext_nodelay;
        @(posedge mclk) disable iff (reset)
        (clk_en && !crystal) |-> ##1 (!clk_en || !startup_busy_ff);
    endproperty
    a_ext_nodelay: assert property (p_ext_nodelay) else $error("timer in ext mode");

    property p_restart;
        @(posedge mclk) disable iff (reset)
        (clk_en && trigger && crystal) |=> startup_busy_ff && !xtal_done;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

endmodule : ossel_top

// ---- common/ossel_pkg.sv ----
package ossel_pkg;

    // ****************************************************************
    // Configuration oscillator-type codes
    // ****************************************************************
    localparam logic [2:0] OSC_TYPE_WATCH_XTAL = 3'h0;
    localparam logic [2:0] OSC_TYPE_MID_XTAL   = 3'h1;
    localparam logic [2:0] OSC_TYPE_HIGH_XTAL  = 3'h2;
    localparam logic [2:0] OSC_TYPE_RES_CAP    = 3'h3;
    localparam logic [2:0] OSC_TYPE_INTERNAL   = 3'h4;
    localparam logic [2:0] OSC_TYPE_EXT_LOW    = 3'h5;
    localparam logic [2:0] OSC_TYPE_EXT_MID    = 3'h6;
    localparam logic [2:0] OSC_TYPE_EXT_HIGH   = 3'h7;

    // ****************************************************************
    // Source select field codes
    // ****************************************************************
    localparam logic [1:0] SRC_SEL_PRIMARY   = 2'h0;
    localparam logic [1:0] SRC_SEL_SECONDARY = 2'h1;

    // ****************************************************************
    // Amplifier gain codes
    // ****************************************************************
    localparam logic [1:0] GAIN_OFF  = 2'h0;
    localparam logic [1:0] GAIN_LOW  = 2'h1;
    localparam logic [1:0] GAIN_MID  = 2'h2;
    localparam logic [1:0] GAIN_HIGH = 2'h3;

    // ****************************************************************
    // Multiplier codes
    // ****************************************************************
    localparam logic [1:0] MULT_BYPASS = 2'h0;
    localparam logic [1:0] MULT_X3     = 2'h1;
    localparam logic [1:0] MULT_X4     = 2'h2;

    // ****************************************************************
    // Counts and reset values
    // ****************************************************************
    localparam int         STARTUP_OSC_COUNT  = 1024;
    localparam int         FAST_START_CYCLES  = 16;
    localparam int         FAILSAFE_TIMEOUT   = 64;
    localparam logic [3:0] IRCF_RESET         = 4'h7;

    // ****************************************************************
    // Selected system clock source
    // ****************************************************************
    typedef enum logic [2:0] {
        SRC_EXTERNAL,
        SRC_SECONDARY,
        SRC_FAST_START,
        SRC_FAST_INT,
        SRC_SLOW_INT
    } ossel_src_t;

endpackage : ossel_pkg

// ---- logic/ossel_timer.sv ----
module ossel_timer #(
    parameter int WIDTH = 11
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // Control
    input  wire logic             restart,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] target,
    // Status
    output      logic             done_ff
);

    // ****************************************************************
    // Restartable counter with registered done flag
    // ****************************************************************
    logic [WIDTH-1:0] cnt_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_ff <= '0;
        end else if (clk_en) begin
            if (restart) begin
                cnt_ff <= '0;
            end else if (tick && !done_ff) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                done_ff <= 1'b0;
            end else if (tick && (cnt_ff == target - 1'b1)) begin
                done_ff <= 1'b1;
            end
        end
    end

endmodule : ossel_timer

// ---- bench/ossel_osc_model.sv ----
module ossel_osc_model #(
    parameter int HALF = 2
) (
    // Clock
    input  wire logic mclk,
    // Control
    input  wire logic run,
    // Oscillator pin
    output      logic osc_input_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt;

    // ****************************************************************
    // Crystal or external source, stands still when it fails
    // ****************************************************************
    initial begin
        osc_input_pin = 1'b0;
        cnt = 0;
    end

    always @(negedge mclk) begin
        if (run) begin
            if (cnt == HALF - 1) begin
                cnt <= 0;
                osc_input_pin <= ~osc_input_pin;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end

endmodule : ossel_osc_model

// ---- bench/tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int START_N = 8;
    localparam int FAST_N  = 2;
    localparam int FAIL_N  = 8;
    localparam int HALF_N  = 2;
    localparam int NOM     = START_N * 2 * HALF_N;

    logic       mclk, reset, clk_en, cfg_mult_enable, failsafe_enable, two_speed_enable;
    logic [2:0] osc_type_cfg;
    logic [1:0] sysclk_source_sel;
    logic [3:0] int_freq_sel;
    logic       soft_mult_enable, soft_mult_select, powerup_timer_done, wake_event;
    logic       osc_input_pin, osc_run;
    logic [2:0] clk_source_ff;
    logic [1:0] amp_gain_ff, mult_mode_ff;
    logic [3:0] int_freq_ff;
    logic       cpu_run_ff, startup_busy_ff, failsafe_trip_ff, osc_stable_ff;
    int         error_cnt, checks, n, k;

    logic [2:0] ext_codes [4] = '{ossel_pkg::OSC_TYPE_RES_CAP, ossel_pkg::OSC_TYPE_EXT_LOW,
                                  ossel_pkg::OSC_TYPE_EXT_MID, ossel_pkg::OSC_TYPE_EXT_HIGH};
    logic [4:0] mult_tab [5] = '{{3'h1, ossel_pkg::MULT_BYPASS}, {3'h3, ossel_pkg::MULT_X3},
                                 {3'h2, ossel_pkg::MULT_X4}, {3'h5, ossel_pkg::MULT_X3},
                                 {3'h4, ossel_pkg::MULT_X4}};
    logic [1:0] sel_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    ossel_pkg::ossel_src_t sel_exp [4] = '{ossel_pkg::SRC_SECONDARY, ossel_pkg::SRC_FAST_INT,
                                           ossel_pkg::SRC_FAST_INT, ossel_pkg::SRC_EXTERNAL};

    ossel_top #(.FAILSAFE_CYCLES(FAIL_N), .STARTUP_COUNT(START_N), .FAST_CYCLES(FAST_N)) dut (
        .mclk(mclk), .reset(reset), .clk_en(clk_en), .osc_type_cfg(osc_type_cfg),
        .cfg_mult_enable(cfg_mult_enable), .failsafe_enable(failsafe_enable),
        .two_speed_enable(two_speed_enable), .sysclk_source_sel(sysclk_source_sel),
        .int_freq_sel(int_freq_sel), .soft_mult_enable(soft_mult_enable),
        .soft_mult_select(soft_mult_select), .powerup_timer_done(powerup_timer_done),
        .wake_event(wake_event), .osc_input_pin(osc_input_pin),
        .clk_source_ff(clk_source_ff), .amp_gain_ff(amp_gain_ff), .mult_mode_ff(mult_mode_ff),
        .int_freq_ff(int_freq_ff), .cpu_run_ff(cpu_run_ff), .startup_busy_ff(startup_busy_ff),
        .failsafe_trip_ff(failsafe_trip_ff), .osc_stable_ff(osc_stable_ff));

    ossel_osc_model #(.HALF(HALF_N)) osc (
        .mclk(mclk), .run(osc_run), .osc_input_pin(osc_input_pin));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task tick(input int c);
        repeat (c) @(negedge mclk);
    endtask : tick

    task check(input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task results;
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task trigger(input logic wake);
        if (wake) wake_event = 1'b1;
        else powerup_timer_done = 1'b1;
        tick(3);
        wake_event = 1'b0;
        powerup_timer_done = 1'b0;
    endtask : trigger

    task wait_busy;
        k = 0;
        while (startup_busy_ff !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
    endtask : wait_busy

    task count_busy(output int c);
        c = 0;
        while (startup_busy_ff === 1'b1 && c < 300) begin
            tick(1);
            c++;
        end
    endtask : count_busy

    // ****************************************************************
    // Clock and watchdog
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        #(50 * 5000);
        error_cnt++;
        results();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        error_cnt = 0; checks = 0; reset = 1'b1; clk_en = 1'b1; osc_run = 1'b1;
        osc_type_cfg = ossel_pkg::OSC_TYPE_EXT_HIGH; cfg_mult_enable = 1'b0;
        failsafe_enable = 1'b0; two_speed_enable = 1'b0; sysclk_source_sel = 2'h0;
        int_freq_sel = 4'h7; soft_mult_enable = 1'b0; soft_mult_select = 1'b0;
        powerup_timer_done = 1'b0; wake_event = 1'b0;
        tick(4);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_FAST_START));
        check(int_freq_ff, ossel_pkg::IRCF_RESET);
        check({cpu_run_ff, startup_busy_ff, failsafe_trip_ff, osc_stable_ff}, 4'h0);
        check({amp_gain_ff, mult_mode_ff}, 4'h0);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            osc_type_cfg = ext_codes[i];
            tick(4);
            check(4'(clk_source_ff), 4'(ossel_pkg::SRC_EXTERNAL));
            check({2'h0, amp_gain_ff}, 4'(ossel_pkg::GAIN_OFF));
        end
        trigger(1'b1);
        tick(4);
        check({2'h0, startup_busy_ff, cpu_run_ff}, 4'h1);
        for (int i = 0; i < 3; i++) begin
            osc_type_cfg = 3'(i);
            tick(3);
            check({2'h0, amp_gain_ff}, 4'(i + 1));
        end
        for (int i = 0; i < 5; i++) begin
            {cfg_mult_enable, soft_mult_enable, soft_mult_select} = mult_tab[i][4:2];
            tick(3);
            check({2'h0, mult_mode_ff}, {2'h0, mult_tab[i][1:0]});
        end
        osc_type_cfg = ossel_pkg::OSC_TYPE_INTERNAL;
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        tick(1);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_FAST_START));
        tick(FAST_N + 4);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_FAST_INT));
        int_freq_sel = 4'h0;
        tick(3);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_SLOW_INT));
        check(int_freq_ff, 4'h0);
        int_freq_sel = 4'h5;
        osc_type_cfg = ossel_pkg::OSC_TYPE_EXT_MID;
        for (int i = 0; i < 4; i++) begin
            sysclk_source_sel = sel_tab[i];
            tick(FAST_N + 4);
            check(4'(clk_source_ff), 4'(sel_exp[i]));
        end
        clk_en = 1'b0;
        sysclk_source_sel = 2'h1;
        tick(4);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_EXTERNAL));
        clk_en = 1'b1;
        tick(3);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_SECONDARY));
        sysclk_source_sel = 2'h0;
        osc_type_cfg = ossel_pkg::OSC_TYPE_HIGH_XTAL;
        tick(3);
        trigger(1'b0);
        wait_busy();
        check({3'h0, startup_busy_ff}, 4'h1);
        tick(1);
        check({3'h0, cpu_run_ff}, 4'h0);
        count_busy(n);
        check({3'h0, 1'(n >= NOM - 6 && n <= NOM + 6)}, 4'h1);
        tick(1);
        check({2'h0, osc_stable_ff, cpu_run_ff}, 4'h3);
        two_speed_enable = 1'b1;
        trigger(1'b1);
        wait_busy();
        tick(2);
        check({3'h0, cpu_run_ff}, 4'h1);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_FAST_INT));
        tick(8);
        trigger(1'b1);
        count_busy(n);
        check({3'h0, 1'(n >= NOM - 6)}, 4'h1);
        two_speed_enable = 1'b0;
        failsafe_enable = 1'b1;
        tick(6);
        check({3'h0, failsafe_trip_ff}, 4'h0);
        osc_run = 1'b0;
        k = 0;
        while (failsafe_trip_ff !== 1'b1 && k < FAIL_N + 20) begin
            tick(1);
            k++;
        end
        check({3'h0, failsafe_trip_ff}, 4'h1);
        tick(1);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_FAST_INT));
        osc_run = 1'b1;
        tick(20);
        check({3'h0, failsafe_trip_ff}, 4'h1);
        osc_type_cfg = ossel_pkg::OSC_TYPE_EXT_LOW;
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        tick(4);
        check(4'(clk_source_ff), 4'(ossel_pkg::SRC_EXTERNAL));
        check({3'h0, failsafe_trip_ff}, 4'h0);
        results();
    end

endmodule : tb
